// *** design/sbpc_sram_port.sv ***
`timescale 1ns/1ps
`include "sbpc_params.svh"

// Behaviour
// RL1 - third select, active low, sampled on edge
// RL2 - first low, second high, sampled on edge
// RL3 - selected only with all three active
// RL4 - low output enable drives data combinationally
// RL5 - high output enable floats the data lines
// RL6 - float during write data, wake, deselect
// RL7 - qualifier high ignores edge, holds state
// RL8 - qualifier high never deselects, extends cycle
// RL9 - input data captured into data register
// RL10 - read data one cycle after address
// RL11 - parity lines behave like data lines
// RL12 - lane selects gate byte and parity
// RL13 - strap high interleaved, low linear
// RL14 - system keeps strap fixed during operation
// RL15 - open strap treated as interleaved
// RL16 - controller drives write enable low
// RL17 - advance steps counter, low loads address
module sbpc_sram_port #(
  parameter int ADDR_W  = `SBPC_ADDR_W,
  parameter int LANES   = `SBPC_LANES,
  parameter int BYTE_W  = `SBPC_BYTE_W,
  parameter int BURST_W = `SBPC_BURST_W
) (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic                    chip_select_first_n,
  input  wire logic                    chip_select_second,
  input  wire logic                    chip_select_third_n,
  input  wire logic                    write_enable_n,
  input  wire logic                    advance_or_load,
  input  wire logic [LANES-1:0]        byte_lane_write_n,
  input  wire logic                    clock_qualify_n,
  input  wire logic                    output_enable_n,
  input  wire logic                    burst_order_strap,
  input  wire logic [LANES*BYTE_W-1:0] data_in,
  output logic      [LANES*BYTE_W-1:0] data_out,
  output logic      [LANES*BYTE_W-1:0] data_oe,
  input  wire logic [LANES-1:0]        parity_lines_in,
  output logic      [LANES-1:0]        parity_lines_out,
  output logic      [LANES-1:0]        parity_lines_oe
);

  localparam int WORD_W = LANES * (BYTE_W + 1);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  sbpc_pkg::sbpc_op_t op_r, op_nxt;
  logic [ADDR_W-1:0]  base_r, base_nxt;
  logic [BURST_W-1:0] cnt_r, cnt_nxt;
  logic [LANES-1:0]   lanes_r, lanes_nxt;
  logic               strap_r, strap_nxt;
  logic               strap_taken_r, strap_taken_nxt;
  logic               drive_r, drive_nxt;
  logic [WORD_W-1:0]  out_word_r, out_word_nxt;
  logic [WORD_W-1:0]  in_word_r, in_word_nxt;
  logic [ADDR_W-1:0]  wr_addr_r, wr_addr_nxt;
  logic [LANES-1:0]   wr_lanes_r, wr_lanes_nxt;
  logic               wr_pend_r, wr_pend_nxt;
  logic [WORD_W-1:0]  mem [2**ADDR_W];

  logic               qual;
  logic               selected;
  logic [BURST_W-1:0] offset;
  logic [ADDR_W-1:0]  acc_addr;
  logic [WORD_W-1:0]  bus_word;
  logic [WORD_W-1:0]  rd_word;

  assign qual     = ~clock_qualify_n; // RL7
  assign selected = ~chip_select_first_n & chip_select_second & ~chip_select_third_n; // RL1 RL2 RL3

  sbpc_burst_seq #(
    .BURST_W (BURST_W)
  ) u_burst (
    .base       (base_r[BURST_W-1:0]),
    .count      (cnt_r),
    .interleave (strap_r),
    .offset     (offset)
  );

  assign acc_addr = {base_r[ADDR_W-1:BURST_W], offset};

  // one lane is a byte with its parity bit on top
  function automatic logic [WORD_W-1:0] pack_word(input logic [LANES*BYTE_W-1:0] d,
                                                   input logic [LANES-1:0]        p);
    logic [WORD_W-1:0] w;
    w = '0;
    for (int i = 0; i < LANES; i++)
      w[i*(BYTE_W+1) +: (BYTE_W+1)] = {p[i], d[i*BYTE_W +: BYTE_W]}; // RL11
    return w;
  endfunction

  // lanes whose select is low take the new byte, the rest keep the old
  function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] old_w,
                                                    input logic [WORD_W-1:0] new_w,
                                                    input logic [LANES-1:0]  sel_n);
    logic [WORD_W-1:0] w;
    w = old_w;
    for (int i = 0; i < LANES; i++)
      if (!sel_n[i])
        w[i*(BYTE_W+1) +: (BYTE_W+1)] = new_w[i*(BYTE_W+1) +: (BYTE_W+1)]; // RL12
    return w;
  endfunction

  assign bus_word = pack_word(data_in, parity_lines_in);

  // a write still waiting to commit is forwarded, so read-after-write sees it
  always_comb
  begin
    rd_word = mem[acc_addr];
    if (wr_pend_r && wr_addr_r == acc_addr)
      rd_word = merge_word(rd_word, in_word_r, wr_lanes_r);
  end

  // ----------------------------------------------------------------------------
  // address and control stage
  // ----------------------------------------------------------------------------
  always_comb
  begin
    op_nxt          = op_r;
    base_nxt        = base_r;
    cnt_nxt         = cnt_r;
    lanes_nxt       = lanes_r;
    strap_nxt       = strap_r;
    strap_taken_nxt = strap_taken_r;
    if (qual) // RL7 RL8
    begin
      if (!strap_taken_r)
      begin
        strap_nxt       = burst_order_strap; // RL13 RL15
        strap_taken_nxt = 1'b1;
      end
      lanes_nxt = byte_lane_write_n; // RL12
      if (!advance_or_load) // RL17
      begin
        cnt_nxt = `SBPC_BURST_START;
        if (selected)
        begin
          base_nxt = addr;
          op_nxt   = write_enable_n ? sbpc_pkg::SBPC_READ : sbpc_pkg::SBPC_WRITE; // RL16
        end
        else
          op_nxt = sbpc_pkg::SBPC_IDLE; // RL3
      end
      else if (op_r != sbpc_pkg::SBPC_IDLE)
        cnt_nxt = cnt_r + `SBPC_BURST_STEP; // RL17
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_r          <= sbpc_pkg::SBPC_IDLE;
      base_r        <= '0;
      cnt_r         <= `SBPC_BURST_START;
      lanes_r       <= '1;
      strap_r       <= `SBPC_STRAP_DEFAULT;
      strap_taken_r <= 1'b0;
    end
    else
    begin
      op_r          <= op_nxt;
      base_r        <= base_nxt;
      cnt_r         <= cnt_nxt;
      lanes_r       <= lanes_nxt;
      strap_r       <= strap_nxt;
      strap_taken_r <= strap_taken_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // data stage
  // ----------------------------------------------------------------------------
  always_comb
  begin
    drive_nxt    = drive_r;
    out_word_nxt = out_word_r;
    in_word_nxt  = in_word_r;
    wr_addr_nxt  = wr_addr_r;
    wr_lanes_nxt = wr_lanes_r;
    wr_pend_nxt  = wr_pend_r;
    if (qual) // RL7
    begin
      // only a read stage turns the drivers on; write, deselect and wake stay off
      drive_nxt   = (op_r == sbpc_pkg::SBPC_READ); // RL6 RL10
      wr_pend_nxt = (op_r == sbpc_pkg::SBPC_WRITE);
      if (op_r == sbpc_pkg::SBPC_READ)
        out_word_nxt = rd_word; // RL10
      if (!drive_r)
        in_word_nxt = bus_word; // RL9
      if (op_r == sbpc_pkg::SBPC_WRITE)
      begin
        wr_addr_nxt  = acc_addr;
        wr_lanes_nxt = lanes_r; // RL12
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_r    <= 1'b0;
      out_word_r <= '0;
      in_word_r  <= '0;
      wr_addr_r  <= '0;
      wr_lanes_r <= '1;
      wr_pend_r  <= 1'b0;
    end
    else
    begin
      drive_r    <= drive_nxt;
      out_word_r <= out_word_nxt;
      in_word_r  <= in_word_nxt;
      wr_addr_r  <= wr_addr_nxt;
      wr_lanes_r <= wr_lanes_nxt;
      wr_pend_r  <= wr_pend_nxt;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    if (qual && wr_pend_r)
      mem[wr_addr_r] <= merge_word(mem[wr_addr_r], in_word_r, wr_lanes_r); // RL12
  end

  // ----------------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------------
  // the enable must follow the output-enable pin without a clock, so it is a gate
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      assign data_out[g*BYTE_W +: BYTE_W] = out_word_r[g*(BYTE_W+1) +: BYTE_W];
      assign parity_lines_out[g]          = out_word_r[g*(BYTE_W+1) + BYTE_W]; // RL11
      assign data_oe[g*BYTE_W +: BYTE_W]  = {BYTE_W{drive_r & ~output_enable_n}}; // RL4 RL5
      assign parity_lines_oe[g]           = drive_r & ~output_enable_n; // RL11
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_third_deselect: assert property ( // RL1
    qual && !advance_or_load && chip_select_third_n |=> op_r == sbpc_pkg::SBPC_IDLE)
    else $error("third select high did not deselect");
  chk_second_deselect: assert property ( // RL2
    qual && !advance_or_load && !chip_select_second ##1 qual |=> !drive_r)
    else $error("second select low still drove data");
  chk_all_select: assert property ( // RL3
    qual && !advance_or_load && selected && write_enable_n ##1 qual |=> drive_r)
    else $error("selected read did not drive");
  chk_oe_drive: assert property ( // RL4
    drive_r && !output_enable_n |-> data_oe == '1)
    else $error("drivers off while enabled");
  chk_oe_float: assert property ( // RL5
    output_enable_n |-> data_oe == '0 && parity_lines_oe == '0)
    else $error("drivers on with output enable high");
  chk_write_float: assert property ( // RL6
    qual && op_r != sbpc_pkg::SBPC_READ |=> !drive_r)
    else $error("drivers on in write or deselect");
  chk_qual_hold: assert property ( // RL7 RL8
    !qual |=> $stable(op_r) && $stable(drive_r) && $stable(out_word_r) && $stable(cnt_r))
    else $error("state moved on an ignored edge");
  chk_data_capture: assert property ( // RL9
    rstn && qual && !drive_r |=> in_word_r == $past(bus_word))
    else $error("input data not captured");
  chk_read_latency: assert property ( // RL10
    qual && op_r == sbpc_pkg::SBPC_READ |=> out_word_r == $past(rd_word) && drive_r)
    else $error("read data not presented after one cycle");
  chk_parity_oe: assert property ( // RL11
    parity_lines_oe == {LANES{data_oe[0]}})
    else $error("parity enable differs from data enable");
  chk_lane_gate: assert property ( // RL12
    qual && wr_pend_r && wr_lanes_r == '1 |=> mem[$past(wr_addr_r)] == $past(mem[wr_addr_r]))
    else $error("write with all lanes off changed memory");
  chk_burst_order: assert property ( // RL13
    op_r != sbpc_pkg::SBPC_IDLE && strap_r |-> offset == (base_r[BURST_W-1:0] ^ cnt_r))
    else $error("interleaved order wrong");
  chk_open_strap: assert property ( // RL15
    !strap_taken_r |-> strap_r)
    else $error("strap not interleaved before capture");
  chk_burst_step: assert property ( // RL17
    qual && advance_or_load && op_r != sbpc_pkg::SBPC_IDLE
      |=> cnt_r == $past(cnt_r) + `SBPC_BURST_STEP && $stable(op_r))
    else $error("burst counter did not step");

endmodule // sbpc_sram_port

// *** shared/sbpc_params.svh ***
`ifndef SBPC_PARAMS_SVH
`define SBPC_PARAMS_SVH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define SBPC_ADDR_W        18
`define SBPC_LANES         4
`define SBPC_BYTE_W        8
`define SBPC_BURST_W       2

// ----------------------------------------------------------------------------
// reset and strap values
// ----------------------------------------------------------------------------
// an open strap reads as interleaved, so that is also the value held before capture
`define SBPC_STRAP_DEFAULT 1'b1
`define SBPC_BURST_START   2'h0
`define SBPC_BURST_STEP    2'h1

`endif

// *** shared/sbpc_pkg.sv ***
package sbpc_pkg;

  // ----------------------------------------------------------------------------
  // access kinds held by the address stage
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBPC_IDLE,
    SBPC_READ,
    SBPC_WRITE
  } sbpc_op_t;

endpackage

// *** design/sbpc_burst_seq.sv ***
`timescale 1ns/1ps
`include "sbpc_params.svh"

module sbpc_burst_seq #(
  parameter int BURST_W = `SBPC_BURST_W
) (
  input  wire logic [BURST_W-1:0] base,
  input  wire logic [BURST_W-1:0] count,
  input  wire logic               interleave,
  output logic      [BURST_W-1:0] offset
);

  // ----------------------------------------------------------------------------
  // burst order
  // ----------------------------------------------------------------------------
  // both orders wrap inside the low address bits
  always_comb
  begin
    if (interleave)
      offset = base ^ count; // RL13
    else
      offset = base + count; // RL13
  end

endmodule // sbpc_burst_seq

// *** test/sbpc_ctrl_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// controller side of the sram bus
// ----------------------------------------
module sbpc_ctrl_model (
  input  wire logic   core_clk,
  output logic [3:0]  addr,
  output logic [2:0]  cs,
  output logic        we_n,
  output logic        adv,
  output logic        cq_n,
  output logic        oe_n,
  output logic [3:0]  lanes,
  output logic [35:0] wr_word
);
  initial
  begin
    {addr, cs, we_n, adv, cq_n, oe_n, lanes, wr_word} = {4'h0, 3'h6, 8'h8f, 36'h0};
  end

  // cs is {first_n, second, third_n}; released data lines show the inverted last value
  task automatic step(input logic [2:0] c, input logic w, l_adv, q, o,
                      input logic [3:0] a, l, input logic [35:0] d, input bit drv);
    @(posedge core_clk);
    cs      <= c;
    we_n    <= w;
    adv     <= l_adv;
    cq_n    <= q;
    oe_n    <= o;
    addr    <= a;
    lanes   <= l;
    wr_word <= drv ? d : ~wr_word;
  endtask
endmodule // sbpc_ctrl_model

// *** test/tb_pipelined_sram_pin_control.sv ***
`timescale 1ns/1ps
module tb_pipelined_sram_pin_control;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h6;
  localparam logic [2:0] BAD [3] = '{3'h6, 3'h0, 3'h3};
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        strap = 1'b1;
  logic [3:0]  addr, lanes, p_out, p_oe;
  logic [2:0]  cs;
  logic        we_n, adv, cq_n, oe_n;
  logic [35:0] wr_word;
  logic [35:0] held_w = 36'h0;
  logic [31:0] d_out, d_oe;
  logic        qual = 1'b0;
  logic        held_drv = 1'b0;
  logic [35:0] q[$];
  logic [35:0] mem [16];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  // the wire level is whoever drives it, per bit
  wire  [31:0] dbus = (d_oe & d_out) | (~d_oe & wr_word[31:0]);
  wire  [3:0]  pbus = (p_oe & p_out) | (~p_oe & wr_word[35:32]);

  always #50 core_clk = ~core_clk;

  sbpc_ctrl_model ctl (.core_clk(core_clk), .addr(addr), .cs(cs), .we_n(we_n), .adv(adv),
    .cq_n(cq_n), .oe_n(oe_n), .lanes(lanes), .wr_word(wr_word));

  sbpc_sram_port #(.ADDR_W(4)) uut (
    .core_clk(core_clk), .rstn(rstn), .addr(addr), .chip_select_first_n(cs[2]),
    .chip_select_second(cs[1]), .chip_select_third_n(cs[0]), .write_enable_n(we_n),
    .advance_or_load(adv), .byte_lane_write_n(lanes), .clock_qualify_n(cq_n),
    .output_enable_n(oe_n), .burst_order_strap(strap), .data_in(dbus), .data_out(d_out),
    .data_oe(d_oe), .parity_lines_in(pbus), .parity_lines_out(p_out), .parity_lines_oe(p_oe));

  task automatic check(input string what, input logic [35:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    check("pending reads", q.size(), 0);
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge core_clk)
    qual <= rstn & ~cq_n;

  always @(negedge core_clk)
    if (!rstn)
    begin
      held_drv <= 1'b0;
      held_w   <= 36'h0;
    end
    else
    begin
      check("oe bits", {p_oe, d_oe}, {36{d_oe[0]}});
      if (!qual)
      begin
        check("stall oe", d_oe[0], held_drv & ~oe_n);
        check("stall data", {p_out, d_out}, held_w);
      end
      else if (d_oe[0] === 1'b1)
      begin
        if (q.size() == 0)
          check("stray drive", 1, 0);
        else
          check("read word", {p_out, d_out}, q.pop_front());
      end
      if (qual)
      begin
        held_drv <= d_oe[0];
        held_w   <= {p_out, d_out};
      end
    end

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  task automatic nop(input logic cq = 1'b0, input logic oe = 1'b0);
    ctl.step(DES, 1'b1, 1'b0, cq, oe, 4'h0, 4'hf, 36'h0, 1'b0);
  endtask

  // lanes held over both cycles so either sampling edge sees the same select
  task automatic wr(input logic [3:0] a, l, input logic [35:0] w);
    ctl.step(SEL, 1'b0, 1'b0, 1'b0, 1'b0, a, l, 36'h0, 1'b0);
    ctl.step(DES, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, l, w, 1'b1);
    for (int i = 0; i < 4; i++)
      if (!l[i])
      begin
        mem[a][8*i+:8] = w[8*i+:8];
        mem[a][32+i]   = w[32+i];
      end
  endtask

  task automatic rd(input logic [3:0] a, input int n, input logic il);
    for (int k = 0; k < n; k++)
    begin
      ctl.step(SEL, 1'b1, k != 0, 1'b0, 1'b0, a, 4'hf, 36'h0, 1'b0);
      q.push_back(mem[{a[3:2], (il ? (a[1:0] ^ k[1:0]) : 2'(a[1:0] + k[1:0]))}]);
    end
    repeat (2) nop();
  endtask

  initial
  begin
    #(3000 * 100);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(12));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 16; a++)
      wr(a[3:0], 4'h0, 36'({$urandom(), $urandom()}));
    for (int i = 0; i < 8; i++)
      wr(4'($urandom_range(15)), 4'($urandom()), 36'({$urandom(), $urandom()}));
    wr(4'h2, 4'hf, 36'({$urandom(), $urandom()}));
    for (int a = 0; a < 16; a++)
      rd(a[3:0], 1, 1'b1);
    foreach (BAD[i])
    begin
      ctl.step(BAD[i], 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'hf, 36'h0, 1'b0);
      ctl.step(SEL, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 4'hf, 36'h0, 1'b0);
      nop();
    end
    // stall while the read word is on the pins, toggling output enable meanwhile
    ctl.step(SEL, 1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 4'hf, 36'h0, 1'b0);
    q.push_back(mem[3]);
    nop();
    nop(1'b1, 1'b0);
    nop(1'b1, 1'b1);
    nop(1'b1, 1'b0);
    nop();
    ctl.step(SEL, 1'b1, 1'b0, 1'b0, 1'b1, 4'h9, 4'hf, 36'h0, 1'b0);
    nop(1'b0, 1'b1);
    nop(1'b0, 1'b1);
    nop();
    rd(4'h6, 4, 1'b1);
    rd(4'($urandom_range(15)), 4, 1'b1);
    // strap only moves while reset is held
    @(posedge core_clk);
    rstn  <= 1'b0;
    strap <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(4'h5, 4, 1'b0);
    repeat (3) nop();
    end_of_test();
  end
endmodule // tb_pipelined_sram_pin_control
